// File: ssb_pkg.sv
// Purpose: Shared constants for the power-down and borrow-subtract execution block
// Assumes: 8-bit data path, 16-bit opcodes, classic Wishbone register access
// Notes: Offsets are word byte addresses on a 32-bit bus
package ssb_pkg;

    // ****************************************
    // Opcodes
    // ****************************************
    localparam logic [15:0] OP_POWER_DOWN = 16'h0003;
    localparam logic [5:0] OP_SUBB_TOP = 6'h15;
    localparam int OP_TOP_HI = 15;
    localparam int OP_TOP_LO = 10;
    localparam int OP_DEST_BIT = 9;
    localparam int OP_BANK_BIT = 8;
    localparam logic [7:0] IDX_LIMIT = 8'h5f;

    // ****************************************
    // Phases
    // ****************************************
    typedef enum logic [1:0] {PH_DECODE, PH_READ, PH_PROCESS, PH_WRITE} ssb_phase_t;
    typedef enum logic [1:0] {EX_NONE, EX_SLEEP, EX_SUBB} ssb_op_t;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] REG_OPCODE = 8'h00;
    localparam logic [7:0] REG_CTRL = 8'h04;
    localparam logic [7:0] REG_ACC = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0c;
    localparam logic [7:0] REG_BANK = 8'h10;
    localparam logic [7:0] REG_FSR2 = 8'h14;
    localparam logic [7:0] REG_FILE = 8'h18;
    localparam logic [7:0] REG_WDT = 8'h1c;

    // Status field positions
    localparam int ST_CARRY = 0;
    localparam int ST_HALF = 1;
    localparam int ST_ZERO = 2;
    localparam int ST_OVF = 3;
    localparam int ST_NEG = 4;
    localparam int ST_PD = 5;
    localparam int ST_TO = 6;
    localparam int ST_HALT = 7;
    // Control field positions
    localparam int CT_GO = 0;
    localparam int CT_EXT = 1;
    localparam int CT_WAKE = 2;
    localparam int CT_WAKE_WDT = 3;

    localparam logic [7:0] RST_STATUS = 8'h60;
    localparam logic [7:0] WDT_RESET = 8'h00;
    localparam int FILE_DEPTH = 16;
    localparam logic [7:0] ACCESS_SPLIT = 8'h60;
    localparam logic [3:0] ACCESS_HI_BANK = 4'hf;
endpackage

// File: ssb_decode.sv
// Purpose: Opcode classifier
// Assumes: Opcode stable during decode phase
// Notes: Purely combinational
`timescale 1ns/10ps
module ssb_decode
(
    // Instruction
    input wire logic [15:0] opcode,
    // Class
    output ssb_pkg::ssb_op_t opClass
);
    always_comb
    begin
        if (opcode == ssb_pkg::OP_POWER_DOWN)
            opClass = ssb_pkg::EX_SLEEP;
        else if (opcode[ssb_pkg::OP_TOP_HI:ssb_pkg::OP_TOP_LO] == ssb_pkg::OP_SUBB_TOP)
            opClass = ssb_pkg::EX_SUBB;
        else
            opClass = ssb_pkg::EX_NONE;
    end
endmodule

// File: ssb_alu.sv
// Purpose: Accumulator minus file minus inverted carry
// Assumes: 8-bit two's complement operands
// Notes: Combinational, flags follow the difference
`timescale 1ns/10ps
module ssb_alu
(
    // Operands
    input wire logic [7:0] acc,
    input wire logic [7:0] fileVal,
    input wire logic carryIn,
    // Result
    output logic [7:0] diff,
    output logic carry,
    output logic halfCarry,
    output logic overflow,
    output logic zero,
    output logic negative
);
    logic [8:0] wide;
    logic [4:0] low;
    always_comb
    begin
        // Carry set means no borrow
        wide = {1'b0, acc} + {1'b0, ~fileVal} + {8'h00, carryIn};
        low = {1'b0, acc[3:0]} + {1'b0, ~fileVal[3:0]} + {4'h0, carryIn};
        diff = wide[7:0];
        carry = wide[8];
        halfCarry = low[4];
        overflow = (acc[7] != fileVal[7]) && (wide[7] != acc[7]);
        zero = (wide[7:0] == 8'h00);
        negative = wide[7];
    end
endmodule

// File: ssb_exec.sv
// Purpose: Execution of power-down and subtract-with-borrow
// Assumes: One instruction per four-phase cycle, one phase per clock
// Notes: Software loads opcode and pulses go, via Wishbone
//
// Function
// - Opcode 0x0003 decodes as power-down, no operands.
// - Power-down clears watchdog counter and its postscaler.
// - Power-down sets timeout_status and clears power_down_status.
// - Core halts with oscillator stopped, entered in phase four.
// - Wake by watchdog time-out clears timeout_status.
// - Opcode 0101 01da decodes as subtract: acc minus file minus not carry.
// - Two's complement; negative, overflow, carry, half carry, zero updated.
// - Destination bit one writes file, zero writes accumulator.
// - Bank bit zero uses access bank; one uses bank_pointer_reg.
// - Bank zero, extended set, address up to 0x5F uses indexed offset.
//
// Chosen here: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/10ps
module ssb_exec
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Core status
    output logic oscRun,
    output logic [7:0] watchdog_counter,
    output logic [7:0] wdtPostscaler
);
    // ****************************************
    // State
    // ****************************************
    logic [15:0] opcode;
    logic busy;
    logic extSet;
    ssb_pkg::ssb_phase_t phase;
    ssb_pkg::ssb_op_t opClass;
    ssb_pkg::ssb_op_t curOp;
    logic [7:0] acc;
    logic [7:0] status;
    logic [3:0] bank_pointer_reg;
    logic [7:0] idxBase;
    logic [7:0] fileMem [ssb_pkg::FILE_DEPTH];
    logic [3:0] fileIdx;
    logic [7:0] opnd;
    logic [7:0] diff;
    logic carry;
    logic half_byte_carry;
    logic signed_range_exceeded_flag;
    logic zero;
    logic negative;
    logic [7:0] result;
    logic [4:0] flags;
    logic wbWrite;
    logic wbRead;
    logic goPulse;
    logic wakePulse;
    logic wakeByWdt;
    logic [3:0] wbFileIdx;

    // Word aligned file port: low nibble of the word offset picks the entry
    function automatic logic [3:0] file_slot(input logic [7:0] addr);
        file_slot = addr[3:0];
    endfunction

    assign wbWrite = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
    assign wbRead = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign goPulse = wbWrite && wb_adr_i == ssb_pkg::REG_CTRL && wb_dat_i[ssb_pkg::CT_GO];
    assign wakePulse = wbWrite && wb_adr_i == ssb_pkg::REG_CTRL
        && wb_dat_i[ssb_pkg::CT_WAKE];
    assign wakeByWdt = wb_dat_i[ssb_pkg::CT_WAKE_WDT];
    // One file entry per 32-bit word: drop the byte lanes before taking the slot
    assign wbFileIdx = file_slot((wb_adr_i - ssb_pkg::REG_FILE) >> 2);

    ssb_decode u_decode
    (
        .opcode(opcode),
        .opClass(opClass)
    );

    // ****************************************
    // Operand addressing
    // ****************************************
    always_comb
    begin
        if (!opcode[ssb_pkg::OP_BANK_BIT])
        begin
            if (extSet && opcode[7:0] <= ssb_pkg::IDX_LIMIT)
                fileIdx = file_slot(idxBase + opcode[7:0]);
            else if (opcode[7:0] >= ssb_pkg::ACCESS_SPLIT)
                fileIdx = ssb_pkg::ACCESS_HI_BANK ^ opcode[3:0];
            else
                fileIdx = opcode[3:0];
        end
        else
        begin
            fileIdx = bank_pointer_reg ^ opcode[3:0];
        end
    end

    ssb_alu u_alu
    (
        .acc(acc),
        .fileVal(opnd),
        .carryIn(status[ssb_pkg::ST_CARRY]),
        .diff(diff),
        .carry(carry),
        .halfCarry(half_byte_carry),
        .overflow(signed_range_exceeded_flag),
        .zero(zero),
        .negative(negative)
    );

    // ****************************************
    // Phase sequencer
    // ****************************************
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            busy <= 1'b0;
            phase <= ssb_pkg::PH_DECODE;
            curOp <= ssb_pkg::EX_NONE;
        end
        else if (busy)
        begin
            case (phase)
                ssb_pkg::PH_DECODE:
                begin
                    curOp <= opClass;
                    phase <= ssb_pkg::PH_READ;
                end
                ssb_pkg::PH_READ: phase <= ssb_pkg::PH_PROCESS;
                ssb_pkg::PH_PROCESS: phase <= ssb_pkg::PH_WRITE;
                ssb_pkg::PH_WRITE:
                begin
                    phase <= ssb_pkg::PH_DECODE;
                    busy <= 1'b0;
                end
                default: phase <= ssb_pkg::PH_DECODE;
            endcase
        end
        else if (goPulse && !status[ssb_pkg::ST_HALT])
        begin
            busy <= 1'b1;
            phase <= ssb_pkg::PH_DECODE;
        end
    end

    // ****************************************
    // Data path
    // ****************************************
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            opnd <= 8'h00;
            result <= 8'h00;
            flags <= 5'h00;
        end
        else if (busy && curOp == ssb_pkg::EX_SUBB)
        begin
            if (phase == ssb_pkg::PH_READ)
                opnd <= fileMem[fileIdx];
            if (phase == ssb_pkg::PH_PROCESS)
            begin
                result <= diff;
                flags <= {negative, signed_range_exceeded_flag, zero,
                    half_byte_carry, carry};
            end
        end
    end

    // Accumulator
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            acc <= 8'h00;
        else if (busy && curOp == ssb_pkg::EX_SUBB && phase == ssb_pkg::PH_WRITE
            && !opcode[ssb_pkg::OP_DEST_BIT])
            acc <= result;
        else if (wbWrite && !busy && wb_adr_i == ssb_pkg::REG_ACC)
            acc <= wb_dat_i[7:0];
    end

    // File registers
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            for (int i = 0; i < ssb_pkg::FILE_DEPTH; i++)
                fileMem[i] <= 8'h00;
        end
        else if (busy && curOp == ssb_pkg::EX_SUBB && phase == ssb_pkg::PH_WRITE
            && opcode[ssb_pkg::OP_DEST_BIT])
            fileMem[fileIdx] <= result;
        else if (wbWrite && !busy && wb_adr_i >= ssb_pkg::REG_FILE
            && wb_adr_i < ssb_pkg::REG_FILE + 8'h40 && wb_adr_i[1:0] == 2'b00)
            fileMem[wbFileIdx] <= wb_dat_i[7:0];
    end

    // ****************************************
    // Status, watchdog and halt
    // ****************************************
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            status <= ssb_pkg::RST_STATUS;
            oscRun <= 1'b1;
        end
        else if (busy && curOp == ssb_pkg::EX_SUBB && phase == ssb_pkg::PH_WRITE)
            status[ssb_pkg::ST_NEG:ssb_pkg::ST_CARRY] <= flags;
        else if (busy && curOp == ssb_pkg::EX_SLEEP && phase == ssb_pkg::PH_PROCESS)
        begin
            status[ssb_pkg::ST_TO] <= 1'b1;
            status[ssb_pkg::ST_PD] <= 1'b0;
        end
        else if (busy && curOp == ssb_pkg::EX_SLEEP && phase == ssb_pkg::PH_WRITE)
        begin
            status[ssb_pkg::ST_HALT] <= 1'b1;
            oscRun <= 1'b0;
        end
        else if (wakePulse && status[ssb_pkg::ST_HALT])
        begin
            status[ssb_pkg::ST_HALT] <= 1'b0;
            oscRun <= 1'b1;
            if (wakeByWdt)
                status[ssb_pkg::ST_TO] <= 1'b0;
        end
        else if (wbWrite && !busy && wb_adr_i == ssb_pkg::REG_STATUS)
            status[ssb_pkg::ST_NEG:ssb_pkg::ST_CARRY] <= wb_dat_i[4:0];
    end

    // Stand-in count so the power-down clear is visible; frozen while halted
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            watchdog_counter <= ssb_pkg::WDT_RESET;
            wdtPostscaler <= ssb_pkg::WDT_RESET;
        end
        else if (busy && curOp == ssb_pkg::EX_SLEEP && phase == ssb_pkg::PH_PROCESS)
        begin
            watchdog_counter <= ssb_pkg::WDT_RESET;
            wdtPostscaler <= ssb_pkg::WDT_RESET;
        end
        else if (oscRun && !(busy && curOp == ssb_pkg::EX_SLEEP))
        begin
            // No count during the rest of power-down, so the cleared value holds
            watchdog_counter <= watchdog_counter + 8'h01;
            if (&watchdog_counter)
                wdtPostscaler <= wdtPostscaler + 8'h01;
        end
    end

    // ****************************************
    // Configuration registers
    // ****************************************
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            opcode <= 16'h0000;
            extSet <= 1'b0;
            bank_pointer_reg <= 4'h0;
            idxBase <= 8'h00;
        end
        else if (wbWrite && !busy)
        begin
            case (wb_adr_i)
                ssb_pkg::REG_OPCODE: opcode <= wb_dat_i[15:0];
                ssb_pkg::REG_CTRL: extSet <= wb_dat_i[ssb_pkg::CT_EXT];
                ssb_pkg::REG_BANK: bank_pointer_reg <= wb_dat_i[3:0];
                ssb_pkg::REG_FSR2: idxBase <= wb_dat_i[7:0];
                default: ;
            endcase
        end
    end

    // ****************************************
    // Wishbone answer
    // ****************************************
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else
        begin
            wb_ack_o <= wbRead;
            wb_dat_o <= 32'h0000_0000;
            if (wbRead)
            begin
                case (wb_adr_i)
                    ssb_pkg::REG_OPCODE: wb_dat_o <= {16'h0000, opcode};
                    ssb_pkg::REG_CTRL: wb_dat_o <= {30'h0000_0000, extSet, busy};
                    ssb_pkg::REG_ACC: wb_dat_o <= {24'h00_0000, acc};
                    ssb_pkg::REG_STATUS: wb_dat_o <= {24'h00_0000, status};
                    ssb_pkg::REG_BANK: wb_dat_o <= {28'h000_0000, bank_pointer_reg};
                    ssb_pkg::REG_FSR2: wb_dat_o <= {24'h00_0000, idxBase};
                    ssb_pkg::REG_WDT: wb_dat_o <= {16'h0000, wdtPostscaler, watchdog_counter};
                    default:
                    begin
                        if (wb_adr_i >= ssb_pkg::REG_FILE && wb_adr_i < ssb_pkg::REG_FILE + 8'h40)
                            wb_dat_o <= {24'h00_0000, fileMem[wbFileIdx]};
                    end
                endcase
            end
        end
    end
endmodule

// File: ssb_exec_sva.sv
// Purpose: Port assertions for the power-down and borrow-subtract block
// Assumes: Master holds each request until it samples ack
// Notes: Opcode in flight is tracked from completed bus writes
`timescale 1ns/10ps
module ssb_exec_chk
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Status
    input wire logic oscRun,
    input wire logic [7:0] watchdog_counter,
    input wire logic [7:0] wdtPostscaler
);
    // ****************************************
    // Helper logic
    // ****************************************
    logic [15:0] lastOp;
    logic wrDone;
    logic ctlWr;
    logic goSleep;
    logic goSub;
    logic wake;
    logic wakeTake;
    assign wrDone = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];
    assign ctlWr = wrDone && wb_adr_i == ssb_pkg::REG_CTRL;
    assign goSleep = ctlWr && wb_dat_i[0] && lastOp == ssb_pkg::OP_POWER_DOWN && oscRun;
    assign goSub = ctlWr && wb_dat_i[0] && lastOp[15:10] == ssb_pkg::OP_SUBB_TOP && oscRun;
    assign wake = ctlWr && wb_dat_i[ssb_pkg::CT_WAKE];
    // Taking edge precedes ack, so the wake cause is seen a cycle early
    assign wakeTake = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i
        && wb_adr_i == ssb_pkg::REG_CTRL && wb_dat_i[ssb_pkg::CT_WAKE];
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            lastOp <= 16'h0000;
        end
        else if (wrDone && wb_adr_i == ssb_pkg::REG_OPCODE)
        begin
            lastOp <= wb_dat_i[15:0];
        end
    end
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);
    // ****************************************
    // Assertions
    // ****************************************
    a_sleep_halts: assert property (goSleep |-> ##[1:6] !oscRun)
        else $error("oscillator still running after power-down");
    a_sleep_clears_wdt: assert property (goSleep |-> ##[1:6]
        (watchdog_counter == 8'h00 && wdtPostscaler == 8'h00))
        else $error("watchdog not cleared by power-down");
    a_halt_cause: assert property ($fell(oscRun) |-> lastOp == ssb_pkg::OP_POWER_DOWN)
        else $error("halt without power-down opcode");
    a_wake_cause: assert property ($rose(oscRun) |->
        ($past(wakeTake) || $past(wakeTake, 2) || $past(wakeTake, 3)))
        else $error("oscillator restarted without wake");
    a_wake_resumes: assert property (wake |-> ##[0:3] oscRun)
        else $error("no restart after wake");
    a_status_halted: assert property (wb_ack_o && !wb_we_i && !oscRun
        && wb_adr_i == ssb_pkg::REG_STATUS |-> wb_dat_o[7:5] == 3'b110)
        else $error("halted status bits wrong");
    a_sub_no_halt: assert property (goSub |-> oscRun [*6])
        else $error("subtract stopped the oscillator");
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    c_sleep: cover property (goSleep);
    c_wake: cover property (wake);
    c_sub: cover property (goSub);
endmodule

bind ssb_exec ssb_exec_chk u_chk
(
    .sys_clk(sys_clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .oscRun(oscRun),
    .watchdog_counter(watchdog_counter), .wdtPostscaler(wdtPostscaler)
);

// File: test_sleep_and_subtract_borrow_exec.sv
// Purpose: Self-checking bench for the power-down and borrow-subtract block
// Assumes: Classic Wishbone single cycles, ack one cycle after take
// Notes: Expected flags are worked out here from the operands
`timescale 1ns/10ps
module test_sleep_and_subtract_borrow_exec;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'hf;
    logic [31:0] datIn = 32'h0000_0000;
    logic [31:0] datOut;
    logic ack;
    logic oscRun;
    logic [7:0] wdt;
    logic [7:0] post;
    logic [31:0] rd;
    logic [31:0] acc0;
    int miscompares = 0;
    int checked = 0;
    int cycles = 0;

    always #2 sys_clk = ~sys_clk;

    ssb_exec u_dut (.sys_clk(sys_clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datIn), .wb_dat_o(datOut),
        .wb_ack_o(ack), .oscRun(oscRun), .watchdog_counter(wdt), .wdtPostscaler(post));

    // ****************************************
    // Tasks
    // ****************************************
    task automatic tally_and_finish();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
        begin
            $display("All checks passed");
        end
        else
        begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Guards against a missing ack or a busy flag that never drops
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            tally_and_finish();
        end
    end

    task automatic checkVal(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        datIn <= d;
        do @(posedge sys_clk); while (ack !== 1'b1);
        rd = datOut;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic rdChk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        xfer(1'b0, a, 32'h0000_0000);
        checkVal(rd & m, e);
    endtask

    task automatic runSub(input logic [7:0] w, input logic [7:0] fv, input logic cin,
        input logic [7:0] f, input logic d, input logic a, input logic ext, input logic [3:0] idx);
        logic [8:0] r;
        logic [4:0] h;
        logic [7:0] fa;
        r = {1'b0, w} - {1'b0, fv} - {8'h00, !cin};
        h = {1'b0, w[3:0]} - {1'b0, fv[3:0]} - {4'h0, !cin};
        fa = 8'h18 + {2'b00, idx, 2'b00};
        xfer(1'b1, ssb_pkg::REG_ACC, {24'h00_0000, w});
        xfer(1'b1, fa, {24'h00_0000, fv});
        xfer(1'b1, ssb_pkg::REG_STATUS, {31'h0000_0000, cin});
        xfer(1'b1, ssb_pkg::REG_OPCODE, {16'h0000, ssb_pkg::OP_SUBB_TOP, d, a, f});
        xfer(1'b1, ssb_pkg::REG_CTRL, {30'h0000_0000, ext, 1'b1});
        rd = 32'h0000_0001;
        while (rd[0] === 1'b1) xfer(1'b0, ssb_pkg::REG_CTRL, 32'h0000_0000);
        rdChk(fa, {24'h00_0000, d ? r[7:0] : fv}, 32'h0000_00ff);
        rdChk(ssb_pkg::REG_ACC, {24'h00_0000, d ? w : r[7:0]}, 32'h0000_00ff);
        rdChk(ssb_pkg::REG_STATUS, {27'h000_0000, r[7], (w[7] ^ fv[7]) & (r[7] ^ w[7]),
            r[7:0] == 8'h00, !h[4], !r[8]}, 32'h0000_001f);
    endtask

    task automatic sleepNow();
        xfer(1'b1, ssb_pkg::REG_OPCODE, 32'h0000_0003);
        xfer(1'b1, ssb_pkg::REG_CTRL, 32'h0000_0001);
        repeat (6) @(posedge sys_clk);
    endtask

    // ****************************************
    // Sequence
    // ****************************************
    initial
    begin
        repeat (16) @(posedge sys_clk);
        rstn <= 1'b1;
        checkVal({15'h0000, oscRun, wdt, post}, 32'h0001_0000);
        rdChk(ssb_pkg::REG_STATUS, 32'h0000_0060, 32'hffff_ffff);
        rdChk(8'h80, 32'h0000_0000, 32'hffff_ffff);
        $display("test reset done");
        xfer(1'b1, ssb_pkg::REG_BANK, 32'h0000_0003);
        xfer(1'b1, ssb_pkg::REG_FSR2, 32'h0000_0005);
        rdChk(ssb_pkg::REG_BANK, 32'h0000_0003, 32'hffff_ffff);
        rdChk(ssb_pkg::REG_FSR2, 32'h0000_0005, 32'hffff_ffff);
        sel <= 4'he;
        xfer(1'b1, ssb_pkg::REG_ACC, 32'h0000_0055);
        sel <= 4'hf;
        rdChk(ssb_pkg::REG_ACC, 32'h0000_0000, 32'hffff_ffff);
        runSub(8'h02, 8'h03, 1'b1, 8'h04, 1'b1, 1'b1, 1'b0, 4'h7);
        runSub(8'h05, 8'h02, 1'b1, 8'h65, 1'b0, 1'b0, 1'b0, 4'ha);
        runSub(8'h02, 8'h01, 1'b0, 8'h5f, 1'b1, 1'b0, 1'b1, 4'h4);
        runSub(8'h80, 8'h01, 1'b1, 8'h05, 1'b0, 1'b0, 1'b0, 4'h5);
        runSub(8'h10, 8'h01, 1'b1, 8'h60, 1'b1, 1'b0, 1'b1, 4'hf);
        $display("test subtract done");
        checkVal({31'h0000_0000, (wdt | post) != 8'h00}, 32'h0000_0001);
        sleepNow();
        checkVal({15'h0000, oscRun, wdt, post}, 32'h0000_0000);
        rdChk(ssb_pkg::REG_WDT, 32'h0000_0000, 32'hffff_ffff);
        rdChk(ssb_pkg::REG_OPCODE, 32'h0000_0003, 32'hffff_ffff);
        rdChk(ssb_pkg::REG_STATUS, 32'h0000_00c0, 32'h0000_00e0);
        xfer(1'b0, ssb_pkg::REG_ACC, 32'h0000_0000);
        acc0 = rd;
        xfer(1'b1, ssb_pkg::REG_OPCODE, 32'h0000_5504);
        xfer(1'b1, ssb_pkg::REG_CTRL, 32'h0000_0001);
        repeat (6) @(posedge sys_clk);
        checkVal({31'h0000_0000, oscRun}, 32'h0000_0000);
        rdChk(ssb_pkg::REG_ACC, acc0, 32'hffff_ffff);
        xfer(1'b1, ssb_pkg::REG_CTRL, 32'h0000_000c);
        repeat (4) @(posedge sys_clk);
        checkVal({31'h0000_0000, oscRun}, 32'h0000_0001);
        rdChk(ssb_pkg::REG_STATUS, 32'h0000_0000, 32'h0000_00e0);
        sleepNow();
        xfer(1'b1, ssb_pkg::REG_CTRL, 32'h0000_0004);
        repeat (4) @(posedge sys_clk);
        rdChk(ssb_pkg::REG_STATUS, 32'h0000_0040, 32'h0000_00e0);
        $display("test power-down done");
        tally_and_finish();
    end
endmodule
